// file: bench/test_touch_i2c_message_port.sv
// Testbench of the touch message port with a bus controller model
`timescale 1ns/1ps
module test_touch_i2c_message_port;
    typedef struct packed
    {
        logic [3:0]  t;
        logic [7:0]  s;
        logic [11:0] x;
        logic [11:0] y;
        logic [7:0]  a;
        logic [7:0]  id;
    } tmp_row_type;
    tmp_row_type rows [3] = '{'{4'h0, 8'h81, 12'hFFF, 12'h000, 8'h0F, 8'h38},
                             '{4'hF, 8'h94, 12'h000, 12'hFFF, 8'h01, 8'h47},
                             '{4'h7, 8'h85, 12'hABC, 12'h123, 8'h22, 8'h3F}};
    logic        clk_i = 1'b0;
    logic        lclk = 1'b0;
    logic        reset_i = 1'b1;
    logic        msg_valid = 1'b0;
    tmp_row_type cur = '0;
    logic [7:0]  rd_data = 8'h00;
    logic        scl, sda_low, sda_o, sda_oe_n, al_n, al_oe_n, ready, wr_stb;
    logic [15:0] wr_addr, rd_addr;
    logic [7:0]  wr_data;
    logic [23:0] wq[$];
    int          bad_count = 0;
    int          comparisons = 0;
    // Pull-ups on both open drain lines
    wire sda_line = ~sda_low & (sda_oe_n | sda_o);
    wire al_line = al_oe_n | al_n;
    tmp_port #(.DEPTH(tmp_pkg::QUEUE_DEPTH)) dut
    (
        .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .change_alert_n_o(al_n),
        .change_alert_oe_n_o(al_oe_n), .msg_valid_i(msg_valid), .msg_touch_i(cur.t),
        .msg_status_i(cur.s), .msg_x_i(cur.x), .msg_y_i(cur.y), .msg_area_i(cur.a),
        .msg_ready_o(ready), .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data)
    );
    tmp_host host
    (
        .lclk_i(lclk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low)
    );
    // System clock and unrelated link clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        #37;
        forever #80 lclk = ~lclk;
    end
    function automatic logic [7:0] mem_f(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    // Outside location store and write capture
    always @(posedge clk_i)
    begin
        rd_data <= mem_f(rd_addr);
        if (wr_stb === 1'b1)
        begin
            wq.push_back({wr_addr, wr_data});
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        logic        ok;
        logic [79:0] exp;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        host.wr_xfer(16'h1234, 3, 8'hC0, ok);
        check(ok, 24'd1);
        check(24'(wq.size()), 24'd3);
        foreach (wq[i])
        begin
            check(wq[i], {16'h1234 + 16'(i), 8'hC0 + 8'(i)});
        end
        host.rd_xfer(2);
        check(host.rx.pop_front(), mem_f(16'h1234));
        check(host.rx.pop_front(), mem_f(16'h1235));
        host.rd_xfer(1);
        check(host.rx.pop_front(), mem_f(16'h1234));
        host.start_c();
        host.send_b(8'hA0, ok);
        host.stop_c();
        check(ok, 24'd0);
        $display("pointer and address test finished");
        // Push every row back to back
        @(posedge clk_i);
        foreach (rows[i])
        begin
            msg_valid <= 1'b1;
            cur <= rows[i];
            @(posedge clk_i);
        end
        msg_valid <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(ready, 24'd1);
        check(al_line, 24'd0);
        host.wr_xfer(tmp_pkg::MSG_COUNT_ADDR, 0, 8'h00, ok);
        host.rd_xfer(1 + 3 * tmp_pkg::MSG_BYTES);
        check(host.rx.pop_front(), 24'd3);
        foreach (rows[i])
        begin
            exp = {24'h000000, rows[i].a, 4'h0, rows[i].y[11:8], rows[i].y[7:0],
                   4'h0, rows[i].x[11:8], rows[i].x[7:0], rows[i].s, rows[i].id};
            for (int k = 0; k < 10; k++)
            begin
                check(host.rx.pop_front(), exp[k * 8 +: 8]);
            end
        end
        repeat (4) @(posedge clk_i);
        check(al_line, 24'd1);
        host.rd_xfer(2);
        check(host.rx.pop_front(), 24'd0);
        check(host.rx.pop_front(), 24'hFF);
        $display("message test finished");
        // Reset with a message pending
        @(posedge clk_i);
        msg_valid <= 1'b1;
        cur <= rows[0];
        @(posedge clk_i);
        msg_valid <= 1'b0;
        @(posedge clk_i);
        check(al_line, 24'd0);
        reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check(al_line, 24'd1);
        host.rd_xfer(1);
        check(host.rx.pop_front(), mem_f(16'h0000));
        $display("reset test finished");
        give_verdict();
    end
endmodule // test_touch_i2c_message_port

// file: bench/tmp_host.sv
// Bus controller model: clocks the bus in frames and reads the data line
`timescale 1ns/1ps
module tmp_host
(
    input  wire logic lclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    logic [7:0] rx[$];
    // Idle bus released
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // One bit: data moves while the clock is low
    task automatic bit_x(input logic b, output logic r);
        @(posedge lclk_i) scl_o = 1'b0;
        @(negedge lclk_i) sda_low_o = ~b;
        @(posedge lclk_i) scl_o = 1'b1;
        @(negedge lclk_i) r = sda_i;
    endtask
    // Start, also repeated: data falls with the clock high
    task automatic start_c();
        logic r;
        bit_x(1'b1, r);
        @(posedge lclk_i) sda_low_o = 1'b1;
    endtask
    // Stop: data rises with the clock high
    task automatic stop_c();
        logic r;
        bit_x(1'b0, r);
        @(posedge lclk_i) sda_low_o = 1'b0;
    endtask
    // Byte out, ack seen low in the ninth bit
    task automatic send_b(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    // Byte in, then ack or nack
    task automatic recv_b(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(nack, r);
    endtask
    // Pointer low then high byte, then n bytes counting up from d0
    task automatic wr_xfer(input logic [15:0] p, input int n, input logic [7:0] d0,
                           output logic ok);
        logic a;
        start_c();
        send_b({tmp_pkg::BUS_ADDR, 1'b0}, ok);
        send_b(p[7:0], a);
        ok = ok & a;
        send_b(p[15:8], a);
        ok = ok & a;
        for (int i = 0; i < n; i++)
        begin
            send_b(d0 + 8'(i), a);
            ok = ok & a;
        end
        stop_c();
    endtask
    // Read n bytes in one transfer, nack on the last, then stop
    task automatic rd_xfer(input int n);
        logic a;
        logic [7:0] d;
        start_c();
        send_b({tmp_pkg::BUS_ADDR, 1'b1}, a);
        for (int i = 0; i < n; i++)
        begin
            recv_b(i == n - 1, d);
            rx.push_back(d);
        end
        stop_c();
    endtask
endmodule // tmp_host

// file: bench/tmp_port_asserts.sv
// Checker of pin drive, alert and push timing at the message port
`timescale 1ns/1ps
module tmp_port_chk
#(
    parameter int DEPTH = tmp_pkg::QUEUE_DEPTH
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic change_alert_n_o,
    input wire logic change_alert_oe_n_o,
    input wire logic msg_valid_i,
    input wire logic msg_ready_o,
    input wire logic wr_stb_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // Open drain pins only pull low
    property p_sda_low; !sda_oe_n_o |-> !sda_o; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
    property p_alert_low; !change_alert_oe_n_o |-> !change_alert_n_o; endproperty
    a_alert_low: assert property (p_alert_low) else $error("alert driven high");
    // Accepted push pulls the alert next edge
    property p_push_alert; clk_en_i && msg_valid_i && msg_ready_o |=> !change_alert_oe_n_o;
    endproperty
    a_push_alert: assert property (p_push_alert) else $error("alert late");
    // Alert stays low while the bus is quiet
    property p_alert_hold;
        (!change_alert_oe_n_o && $stable(scl_i) && $stable(sda_i))[*8] |=> !change_alert_oe_n_o;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert dropped");
    // State right after reset and ready coming back
    property p_rst_vals;
        $fell(reset_i) |-> change_alert_oe_n_o && sda_oe_n_o && !msg_ready_o && !wr_stb_o;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values");
    property p_ready_back; $fell(reset_i) |-> ##[1:3] msg_ready_o; endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready missing");
    // Write strobe is a single pulse in the clock low phase
    property p_wr_pulse; wr_stb_o |-> !scl_i && !$past(scl_i, 2) ##1 !wr_stb_o; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe");
    // Data drive moves only while the bus clock is low
    property p_sda_edge; $changed(sda_oe_n_o) |-> !scl_i; endproperty
    a_sda_edge: assert property (p_sda_edge) else $error("data moved on high");
    c_push: cover property (msg_valid_i && msg_ready_o);
    c_wr: cover property (wr_stb_o);
    c_alert_off: cover property ($rose(change_alert_oe_n_o));
endmodule // tmp_port_chk
bind tmp_port tmp_port_chk #(.DEPTH(DEPTH)) u_chk
(
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .change_alert_n_o(change_alert_n_o),
    .change_alert_oe_n_o(change_alert_oe_n_o), .msg_valid_i(msg_valid_i),
    .msg_ready_o(msg_ready_o), .wr_stb_o(wr_stb_o)
);

// file: verilog/tmp_pkg.sv
// Package of constants for the touch message port
// Contract
// - Answer bus address 0x4B, bit0 read
// - Two pointer bytes, low then high
// - Write data to pointer, incrementing
// - STOP after write restores start pointer
// - Read increments; NACK restores start pointer
// - Pointer rewinds between continuous messages
// - Count byte first, then message bytes
// - Final NACK rewinds to count location
// - Alert asserted when new message available
// - Coordinates span 4096 steps per axis
// - Alert is active low open drain
// - Alert held low while messages queued
// - Report id 38h..47h per touch
// - Empty queue returns report id 255
package tmp_pkg;
    localparam logic [6:0]  BUS_ADDR       = 7'h4B;
    localparam logic [15:0] MSG_COUNT_ADDR = 16'h0182;
    localparam logic [15:0] MSG_PROC_ADDR  = 16'h0183;
    localparam logic [15:0] PTR_RESET      = 16'h0000;
    localparam int          MSG_BYTES      = 10;
    localparam logic [3:0]  MSG_LAST_OFS   = 4'h9;
    localparam logic [7:0]  REPORT_ID_BASE = 8'h38;
    localparam logic [7:0]  REPORT_INVALID = 8'hFF;
    localparam int          QUEUE_DEPTH    = 16;
    localparam int          COORD_BITS     = 12;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

    typedef enum logic [6:0]
    {
        ST_IDLE    = 7'b0000001,
        ST_ADDR    = 7'b0000010,
        ST_ADDR_AK = 7'b0000100,
        ST_WR_BYTE = 7'b0001000,
        ST_WR_AK   = 7'b0010000,
        ST_RD_BYTE = 7'b0100000,
        ST_RD_AK   = 7'b1000000
    } tmp_state_type;
endpackage

// file: verilog/tmp_port.sv
// Touch message port: bus target, pointer, message queue, alert line
`timescale 1ns/1ps
module tmp_port
#(
    parameter int DEPTH = tmp_pkg::QUEUE_DEPTH
)
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    output logic             change_alert_n_o,
    output logic             change_alert_oe_n_o,
    input  wire logic        msg_valid_i,
    input  wire logic [3:0]  msg_touch_i,
    input  wire logic [7:0]  msg_status_i,
    input  wire logic [11:0] msg_x_i,
    input  wire logic [11:0] msg_y_i,
    input  wire logic [7:0]  msg_area_i,
    output logic             msg_ready_o,
    output logic             wr_stb_o,
    output logic [15:0]      wr_addr_o,
    output logic [7:0]       wr_data_o,
    output logic [15:0]      rd_addr_o,
    input  wire logic [7:0]  rd_data_i
);
    localparam int AW  = $clog2(DEPTH);
    localparam int REC = 4 + 8 + 2 * tmp_pkg::COORD_BITS + 8;

    logic                  scl_s;
    logic                  sda_s;
    logic                  scl_d_r;
    logic                  sda_d_r;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    tmp_pkg::tmp_state_type state_r;
    logic [3:0]            bit_cnt_r;
    logic [7:0]            shift_r;
    logic [7:0]            tx_r;
    logic                  read_dir_r;
    logic [1:0]            wr_idx_r;
    logic [15:0]           ptr_r;
    logic [15:0]           start_r;
    logic [REC-1:0]        queue_mem [DEPTH];
    logic [AW-1:0]         head_r;
    logic [AW-1:0]         tail_r;
    logic [AW:0]           count_r;
    logic                  push;
    logic                  pop;
    logic [REC-1:0]        head_rec;
    logic [15:0]           ofs16;
    logic [3:0]            ofs;
    logic                  in_msg;
    logic [7:0]            rd_byte;
    logic [7:0]            msg_byte;

    // Pin inputs cross into the clock domain
    tmp_sync u_sync_scl
    (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .clk_en_i (clk_en_i),
        .async_i  (scl_i),
        .sync_o   (scl_s)
    );

    tmp_sync u_sync_sda
    (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .clk_en_i (clk_en_i),
        .async_i  (sda_i),
        .sync_o   (sda_s)
    );

    // Delayed copies for edge and condition detection
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (clk_en_i)
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Bus events, qualified by the clock enable
    assign scl_rise  = clk_en_i & scl_s & ~scl_d_r;
    assign scl_fall  = clk_en_i & ~scl_s & scl_d_r;
    assign start_det = clk_en_i & scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = clk_en_i & scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Read byte source: count, head message, or external store
    assign head_rec = queue_mem[head_r];
    assign ofs16    = ptr_r - tmp_pkg::MSG_PROC_ADDR;
    assign ofs      = ofs16[3:0];
    assign in_msg   = (ptr_r >= tmp_pkg::MSG_PROC_ADDR) && (ofs16 < 16'(tmp_pkg::MSG_BYTES));

    always_comb
    begin
        msg_byte = 8'h00;
        if (count_r == '0)
        begin
            msg_byte = (ofs == 4'h0) ? tmp_pkg::REPORT_INVALID : 8'h00;
        end
        else
        begin
            unique case (ofs)
                4'h0: msg_byte = tmp_pkg::REPORT_ID_BASE + {4'h0, head_rec[REC-1 -: 4]};
                4'h1: msg_byte = head_rec[39:32];
                4'h2: msg_byte = head_rec[27:20];
                4'h3: msg_byte = {4'h0, head_rec[31:28]};
                4'h4: msg_byte = head_rec[15:8];
                4'h5: msg_byte = {4'h0, head_rec[19:16]};
                4'h6: msg_byte = head_rec[7:0];
                default: msg_byte = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        if (ptr_r == tmp_pkg::MSG_COUNT_ADDR)
            rd_byte = 8'(count_r);
        else if (in_msg)
            rd_byte = msg_byte;
        else
            rd_byte = rd_data_i;
    end

    // Queue push from the touch engine, pop after a message's last byte
    assign push = clk_en_i & msg_valid_i & msg_ready_o;
    assign pop  = (state_r == tmp_pkg::ST_RD_AK) & scl_rise & in_msg
                  & (ofs == tmp_pkg::MSG_LAST_OFS) & (count_r != '0);

    // Queue storage
    always_ff @(posedge clk_i)
    begin
        if (push)
            queue_mem[tail_r] <= {msg_touch_i, msg_status_i, msg_x_i, msg_y_i, msg_area_i};
    end

    // Queue pointers and occupancy
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            head_r  <= '0;
            tail_r  <= '0;
            count_r <= '0;
        end
        else if (clk_en_i)
        begin
            if (push)
                tail_r <= tail_r + 1'b1;
            if (pop)
                head_r <= head_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end

    // Ready toward the touch engine, one slot reserved for the same-cycle push
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            msg_ready_o <= 1'b0;
        else if (clk_en_i)
            msg_ready_o <= (count_r < (AW+1)'(DEPTH - 1)) || ((count_r == (AW+1)'(DEPTH - 1)) && !push);
    end

    // Alert line: open drain, pulled low while messages wait
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            change_alert_n_o    <= 1'b0;
            change_alert_oe_n_o <= 1'b1;
        end
        else if (clk_en_i)
        begin
            change_alert_n_o    <= 1'b0;
            change_alert_oe_n_o <= (count_r == '0) && !push;
        end
    end

    // Bus protocol state machine
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_r    <= tmp_pkg::ST_IDLE;
            bit_cnt_r  <= '0;
            shift_r    <= '0;
            tx_r       <= '0;
            read_dir_r <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end
        else if (stop_det)
        begin
            state_r    <= tmp_pkg::ST_IDLE;
            sda_oe_n_o <= 1'b1;
        end
        else if (start_det)
        begin
            state_r    <= tmp_pkg::ST_ADDR;
            bit_cnt_r  <= '0;
            sda_oe_n_o <= 1'b1;
        end
        else
        begin
            unique case (state_r)
                tmp_pkg::ST_IDLE:
                    sda_oe_n_o <= 1'b1;
                tmp_pkg::ST_ADDR, tmp_pkg::ST_WR_BYTE:
                begin
                    if (scl_rise)
                    begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                    else if (scl_fall && bit_cnt_r == tmp_pkg::BITS_PER_BYTE)
                    begin
                        bit_cnt_r <= '0;
                        if (state_r == tmp_pkg::ST_WR_BYTE)
                        begin
                            state_r    <= tmp_pkg::ST_WR_AK;
                            sda_oe_n_o <= 1'b0;
                        end
                        else if (shift_r[7:1] == tmp_pkg::BUS_ADDR)
                        begin
                            state_r    <= tmp_pkg::ST_ADDR_AK;
                            read_dir_r <= shift_r[0];
                            sda_oe_n_o <= 1'b0;
                        end
                        else
                            state_r <= tmp_pkg::ST_IDLE;
                    end
                end
                tmp_pkg::ST_ADDR_AK, tmp_pkg::ST_WR_AK:
                begin
                    if (scl_fall)
                    begin
                        if (state_r == tmp_pkg::ST_ADDR_AK && read_dir_r)
                        begin
                            state_r    <= tmp_pkg::ST_RD_BYTE;
                            tx_r       <= {rd_byte[6:0], 1'b0};
                            bit_cnt_r  <= 4'h1;
                            sda_oe_n_o <= rd_byte[7];
                        end
                        else
                        begin
                            state_r    <= tmp_pkg::ST_WR_BYTE;
                            sda_oe_n_o <= 1'b1;
                        end
                    end
                end
                tmp_pkg::ST_RD_BYTE:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == tmp_pkg::BITS_PER_BYTE)
                        begin
                            state_r    <= tmp_pkg::ST_RD_AK;
                            sda_oe_n_o <= 1'b1;
                        end
                        else
                        begin
                            sda_oe_n_o <= tx_r[7];
                            tx_r       <= {tx_r[6:0], 1'b0};
                            bit_cnt_r  <= bit_cnt_r + 1'b1;
                        end
                    end
                end
                tmp_pkg::ST_RD_AK:
                begin
                    if (scl_rise)
                        state_r <= sda_s ? tmp_pkg::ST_IDLE : tmp_pkg::ST_RD_AK;
                    else if (scl_fall)
                    begin
                        state_r    <= tmp_pkg::ST_RD_BYTE;
                        tx_r       <= {rd_byte[6:0], 1'b0};
                        bit_cnt_r  <= 4'h1;
                        sda_oe_n_o <= rd_byte[7];
                    end
                end
                default:
                    state_r <= tmp_pkg::ST_IDLE;
            endcase
        end
    end

    // Data line is only ever pulled low
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            sda_o <= 1'b0;
        else
            sda_o <= 1'b0;
    end

    // Address pointer and its saved start value
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ptr_r    <= tmp_pkg::PTR_RESET;
            start_r  <= tmp_pkg::PTR_RESET;
            wr_idx_r <= '0;
        end
        else if (stop_det)
        begin
            ptr_r <= start_r;
        end
        else if (start_det)
        begin
            wr_idx_r <= '0;
            start_r  <= ptr_r;
        end
        else if (state_r == tmp_pkg::ST_WR_BYTE && scl_fall
                 && bit_cnt_r == tmp_pkg::BITS_PER_BYTE)
        begin
            if (wr_idx_r == 2'd0)
            begin
                ptr_r[7:0]   <= shift_r;
                start_r[7:0] <= shift_r;
                wr_idx_r     <= 2'd1;
            end
            else if (wr_idx_r == 2'd1)
            begin
                ptr_r[15:8]   <= shift_r;
                start_r[15:8] <= shift_r;
                wr_idx_r      <= 2'd2;
            end
            else
                ptr_r <= ptr_r + 16'h0001;
        end
        else if (state_r == tmp_pkg::ST_RD_AK && scl_rise)
        begin
            if (sda_s)
                ptr_r <= start_r;
            else if (in_msg && ofs == tmp_pkg::MSG_LAST_OFS)
                ptr_r <= tmp_pkg::MSG_PROC_ADDR;
            else
                ptr_r <= ptr_r + 16'h0001;
        end
    end

    // Write strobe toward the location store
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wr_stb_o  <= 1'b0;
            wr_addr_o <= '0;
            wr_data_o <= '0;
        end
        else if (clk_en_i)
        begin
            wr_stb_o <= (state_r == tmp_pkg::ST_WR_BYTE) && scl_fall && !start_det && !stop_det
                        && (bit_cnt_r == tmp_pkg::BITS_PER_BYTE) && (wr_idx_r == 2'd2);
            wr_addr_o <= ptr_r;
            wr_data_o <= shift_r;
        end
    end

    // Read address follows the pointer
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rd_addr_o <= '0;
        else if (clk_en_i)
            rd_addr_o <= ptr_r;
    end
endmodule // tmp_port

// file: verilog/tmp_sync.sv
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps
module tmp_sync
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic clk_en_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_r;

    // Pin idles high, so both stages reset high
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meta_r <= 1'b1;
            sync_o <= 1'b1;
        end
        else if (clk_en_i)
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // tmp_sync
